// file: rtl/uart_frame_pkg.sv
// Overview of operation
// - Mode field 01 selects seven data bits per character.
// - In 7/8-bit modes parity enable appends parity; even-select picks even.
// - Stop length select sets the number of transmitted stop bits.
// - Mode field 10 selects eight data bits, parity optional.
// - Ninth transmit bit comes from bit 7 of mode control register 0.
// - Ninth received bit lands in bit 7 of the serial control register.
// - 9-bit mode with wake-up set: receive interrupt only if ninth bit is 1.
// - Data frames have ninth bit 0; waking slaves raise no interrupt.
package uart_frame_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] MODE0_OFS  = 4'h0;
    localparam logic [3:0] CTRL_OFS   = 4'h4;
    localparam logic [3:0] MODE2_OFS  = 4'h8;
    localparam logic [3:0] DATA_OFS   = 4'hC;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE0_TB8_BIT   = 7;
    localparam int MODE0_WU_BIT    = 4;
    localparam int MODE0_RXE_BIT   = 5;
    localparam int MODE0_SM_LSB    = 2;
    localparam int CTRL_RB8_BIT    = 7;
    localparam int CTRL_EVEN_BIT   = 6;
    localparam int CTRL_PE_BIT     = 5;
    localparam int CTRL_OERR_BIT   = 4;
    localparam int CTRL_PERR_BIT   = 3;
    localparam int CTRL_FERR_BIT   = 2;
    localparam int MODE2_STOP_LENGTH_SELECT_BIT = 4;
    localparam int MODE2_OD_BIT    = 0;
    localparam int STAT_RX_BIT     = 0;
    localparam int STAT_TX_BIT     = 1;
    localparam int STAT_ERR_BIT    = 2;
    localparam logic [4:0] STAT_OFS = 5'h10;

    // ------------------------------------------------------------
    // Modes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_7BIT = 2'h1;
    localparam logic [1:0] MODE_8BIT = 2'h2;
    localparam logic [1:0] MODE_9BIT = 2'h3;
    localparam logic [7:0] MODE0_RST = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] MODE2_RST = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 40_000_000;
    localparam int BAUD_DEF    = 115_200;
    localparam int OVERSAMPLE  = 16;

endpackage : uart_frame_pkg

// file: rtl/uart_frame_tick.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Oversample enable divider
// ------------------------------------------------------------
module uart_frame_tick
    import uart_frame_pkg::*;
#(
    parameter int DIV = 22
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      tick
);
    initial begin
        if (DIV < 1) $error("DIV must be at least 1");
    end

    logic [15:0] cnt_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
            tick  <= 1'b0;
        end else if (cnt_q == 16'(DIV - 1)) begin
            cnt_q <= 16'h0000;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick  <= 1'b0;
        end
    end
endmodule : uart_frame_tick

// file: rtl/uart_frame_rx.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Receive framer: start, 7/8 data, parity or ninth bit, stop
// ------------------------------------------------------------
module uart_frame_rx
    import uart_frame_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       enable,
    input  wire logic       rxd,
    input  wire logic [1:0] frame_mode_select,
    input  wire logic       parity_enable,
    input  wire logic       even_select,
    output logic            done,
    output logic [7:0]      data,
    output logic            ninth,
    output logic            parity_err,
    output logic            frame_err
);
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_BITS  = 2'b11,
        RX_STOP  = 2'b10
    } rx_state_t;

    rx_state_t   state_q;
    logic [3:0]  sub_q;
    logic [3:0]  idx_q;
    logic [8:0]  sh_q;
    logic [3:0]  nbits;
    logic        has_extra;

    always_comb begin
        has_extra = (frame_mode_select == MODE_9BIT) || parity_enable;
        nbits = ((frame_mode_select == MODE_7BIT) ? 4'h7 : 4'h8) + (has_extra ? 4'h1 : 4'h0);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= RX_IDLE;
            sub_q      <= 4'h0;
            idx_q      <= 4'h0;
            sh_q       <= 9'h000;
            done       <= 1'b0;
            data       <= 8'h00;
            ninth      <= 1'b0;
            parity_err <= 1'b0;
            frame_err  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (tick) begin
                sub_q <= sub_q + 4'h1;
                case (state_q)
                    RX_IDLE: begin
                        sub_q <= 4'h0;
                        if (enable && !rxd) state_q <= RX_START;
                    end
                    RX_START: begin
                        if (sub_q == 4'h7) begin
                            sub_q   <= 4'h0;
                            idx_q   <= 4'h0;
                            state_q <= rxd ? RX_IDLE : RX_BITS;
                        end
                    end
                    RX_BITS: begin
                        if (sub_q == 4'hF) begin
                            sh_q  <= {rxd, sh_q[8:1]};
                            idx_q <= idx_q + 4'h1;
                            if (idx_q == nbits - 4'h1) state_q <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (sub_q == 4'hF) begin
                            state_q   <= RX_IDLE;
                            done      <= 1'b1;
                            frame_err <= !rxd;
                            if (frame_mode_select == MODE_7BIT) begin
                                data       <= {1'b0, has_extra ? sh_q[7:1] : sh_q[8:2]};
                                ninth      <= 1'b0;
                                parity_err <= parity_enable && ((^sh_q[8:1]) == even_select);
                            end else begin
                                data       <= has_extra ? sh_q[7:0] : sh_q[8:1];
                                ninth      <= (frame_mode_select == MODE_9BIT) ? sh_q[8] : 1'b0;
                                parity_err <= parity_enable && (frame_mode_select != MODE_9BIT) &&
                                              ((^sh_q[8:0]) == even_select);
                            end
                        end
                    end
                    default: state_q <= RX_IDLE;
                endcase
            end
        end
    end
endmodule : uart_frame_rx

// file: rtl/uart_frame_top.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Serial channel framing with 7/8/9-bit modes and wake-up filter
// ------------------------------------------------------------
module uart_frame_top
    import uart_frame_pkg::*;
#(
    parameter int BAUD = BAUD_DEF
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [4:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    input  wire logic       rxd,
    output logic            txd_o,
    output logic            txd_oe,
    output logic            receive_irq,
    output logic            irq
);
    localparam int DIV = CLK_HZ / (BAUD * OVERSAMPLE);
    initial begin
        if (DIV < 1) $error("BAUD too high for clock");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] mode_control_0_reg_q;
    logic [7:0] serial_control_reg_q;
    logic [7:0] mode_control_2_reg_q;
    logic [7:0] uart_data_buffer_q;
    logic [2:0] stat_q;
    logic [2:0] mask_q;

    logic [1:0] frame_mode_select;
    logic       parity_enable;
    logic       even_select;
    logic       stop_length_select;
    logic       tx_ninth_bit;
    logic       wakeup_filter_enable;
    logic       open_drain_config_reg;

    assign frame_mode_select    = mode_control_0_reg_q[MODE0_SM_LSB +: 2];
    assign tx_ninth_bit         = mode_control_0_reg_q[MODE0_TB8_BIT];
    assign wakeup_filter_enable = mode_control_0_reg_q[MODE0_WU_BIT];
    assign parity_enable        = serial_control_reg_q[CTRL_PE_BIT];
    assign even_select          = serial_control_reg_q[CTRL_EVEN_BIT];
    assign stop_length_select   = mode_control_2_reg_q[MODE2_STOP_LENGTH_SELECT_BIT];
    assign open_drain_config_reg = mode_control_2_reg_q[MODE2_OD_BIT];

    logic tick;
    logic rx_done;
    logic [7:0] rx_data;
    logic rx_ninth;
    logic rx_perr;
    logic rx_ferr;
    logic rx_accept;
    logic tx_done;
    logic rx_full_q;

    uart_frame_tick #(.DIV(DIV)) u_tick (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

    uart_frame_rx u_rx (
        .clk               (clk),
        .rst               (rst),
        .tick              (tick),
        .enable            (mode_control_0_reg_q[MODE0_RXE_BIT]),
        .rxd               (rxd),
        .frame_mode_select (frame_mode_select),
        .parity_enable     (parity_enable),
        .even_select       (even_select),
        .done              (rx_done),
        .data              (rx_data),
        .ninth             (rx_ninth),
        .parity_err        (rx_perr),
        .frame_err         (rx_ferr)
    );

    // Wake-up filter drops frames with ninth bit clear
    assign rx_accept = rx_done && !((frame_mode_select == MODE_9BIT) && wakeup_filter_enable
                                    && !rx_ninth);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    logic tx_start;
    assign tx_start = wr && (addr == {1'b0, DATA_OFS});

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_control_0_reg_q <= MODE0_RST;
            mode_control_2_reg_q <= MODE2_RST;
            mask_q               <= 3'h0;
        end else if (wr) begin
            case (addr)
                {1'b0, MODE0_OFS}: mode_control_0_reg_q <= wdata;
                {1'b0, MODE2_OFS}: mode_control_2_reg_q <= wdata;
                {1'b1, 4'h4}:      mask_q <= wdata[2:0];
                default: ;
            endcase
        end
    end

    // Control register: software owns PE/EVEN, hardware owns RB8 and errors
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_control_reg_q <= CTRL_RST;
        end else begin
            if (wr && addr == {1'b0, CTRL_OFS}) begin
                serial_control_reg_q[CTRL_EVEN_BIT] <= wdata[CTRL_EVEN_BIT];
                serial_control_reg_q[CTRL_PE_BIT]   <= wdata[CTRL_PE_BIT];
            end
            if (rd && addr == {1'b0, CTRL_OFS}) begin
                serial_control_reg_q[CTRL_OERR_BIT:CTRL_FERR_BIT] <= 3'h0;
            end
            if (rx_accept) begin
                serial_control_reg_q[CTRL_RB8_BIT] <= rx_ninth;
                if (rx_perr) serial_control_reg_q[CTRL_PERR_BIT] <= 1'b1;
                if (rx_ferr) serial_control_reg_q[CTRL_FERR_BIT] <= 1'b1;
                if (rx_full_q) serial_control_reg_q[CTRL_OERR_BIT] <= 1'b1;
            end
        end
    end

    // Receive buffer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            uart_data_buffer_q <= 8'h00;
            rx_full_q          <= 1'b0;
        end else if (rx_accept) begin
            uart_data_buffer_q <= rx_data;
            rx_full_q          <= 1'b1;
        end else if (rd && addr == {1'b0, DATA_OFS}) begin
            rx_full_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status: set wins over read-clear
    // ------------------------------------------------------------
    logic [2:0] stat_set;
    assign stat_set = {rx_accept && (rx_perr || rx_ferr || rx_full_q), tx_done, rx_accept};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_q <= 3'h0;
        end else if (rd && addr == STAT_OFS) begin
            stat_q <= stat_set;
        end else begin
            stat_q <= stat_q | stat_set;
        end
    end

    assign irq         = |(stat_q & mask_q);
    assign receive_irq = stat_q[STAT_RX_BIT];

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                {1'b0, MODE0_OFS}: rdata <= mode_control_0_reg_q;
                {1'b0, CTRL_OFS}:  rdata <= serial_control_reg_q;
                {1'b0, MODE2_OFS}: rdata <= mode_control_2_reg_q;
                {1'b0, DATA_OFS}:  rdata <= uart_data_buffer_q;
                STAT_OFS:          rdata <= {5'h00, stat_q};
                {1'b1, 4'h4}:      rdata <= {5'h00, mask_q};
                default:           rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_RUN  = 2'b01,
        TX_STOP = 2'b11
    } tx_state_t;

    tx_state_t  tx_state_q;
    logic [9:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic [3:0] tx_sub_q;
    logic       tx_stop2_q;
    logic       txd_q;
    logic       tx_extra;
    logic       tx_extra_bit;
    logic [3:0] tx_len;

    always_comb begin
        tx_extra     = (frame_mode_select == MODE_9BIT) || parity_enable;
        if (frame_mode_select == MODE_9BIT) begin
            tx_extra_bit = tx_ninth_bit;
        end else if (frame_mode_select == MODE_7BIT) begin
            tx_extra_bit = (^wdata[6:0]) ^ !even_select;
        end else begin
            tx_extra_bit = (^wdata) ^ !even_select;
        end
        // Start bit plus data plus optional extra bit
        tx_len = ((frame_mode_select == MODE_7BIT) ? 4'h8 : 4'h9) + (tx_extra ? 4'h1 : 4'h0);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state_q <= TX_IDLE;
            tx_sh_q    <= 10'h3FF;
            tx_cnt_q   <= 4'h0;
            tx_sub_q   <= 4'h0;
            tx_stop2_q <= 1'b0;
            txd_q      <= 1'b1;
            tx_done    <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            case (tx_state_q)
                TX_IDLE: begin
                    txd_q <= 1'b1;
                    if (tx_start) begin
                        // Start bit low, data LSB first, extra bit after data
                        if (frame_mode_select == MODE_7BIT) begin
                            tx_sh_q <= {1'b1, tx_extra ? tx_extra_bit : 1'b1, wdata[6:0], 1'b0};
                        end else begin
                            tx_sh_q <= {tx_extra ? tx_extra_bit : 1'b1, wdata, 1'b0};
                        end
                        tx_cnt_q   <= 4'h0;
                        tx_sub_q   <= 4'h0;
                        tx_state_q <= TX_RUN;
                    end
                end
                TX_RUN: begin
                    txd_q <= tx_sh_q[0];
                    if (tick) begin
                        tx_sub_q <= tx_sub_q + 4'h1;
                        if (tx_sub_q == 4'hF) begin
                            tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
                            tx_cnt_q <= tx_cnt_q + 4'h1;
                            if (tx_cnt_q == tx_len - 4'h1) begin
                                tx_state_q <= TX_STOP;
                                tx_stop2_q <= stop_length_select;
                            end
                        end
                    end
                end
                TX_STOP: begin
                    txd_q <= 1'b1;
                    if (tick) begin
                        tx_sub_q <= tx_sub_q + 4'h1;
                        if (tx_sub_q == 4'hF) begin
                            if (tx_stop2_q) begin
                                tx_stop2_q <= 1'b0;
                            end else begin
                                tx_state_q <= TX_IDLE;
                                tx_done    <= 1'b1;
                            end
                        end
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    // Open drain drives only low; push-pull always drives
    assign txd_o  = txd_q;
    assign txd_oe = open_drain_config_reg ? !txd_q : 1'b1;
endmodule : uart_frame_top

// file: verification/uart_frame_props.sv
`timescale 1ns/100ps
// ----------------------------------------
// Frame, drive and register-port checks
// ----------------------------------------
module uart_frame_props
    import uart_frame_pkg::*;
#(
    parameter int BAUD = BAUD_DEF
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       rxd,
    input wire logic       txd_o,
    input wire logic       txd_oe,
    input wire logic       receive_irq,
    input wire logic       irq
);
    localparam int BITC = OVERSAMPLE * (CLK_HZ / (BAUD * OVERSAMPLE));
    logic [7:0]  mode0_q, ctrl_q, mode2_q, mask_q;
    logic [12:0] fr_q;
    int          cnt_q, len_q, pos, nbits;
    logic        take, par, nb;

    assign take  = wr && addr == {1'b0, DATA_OFS} && cnt_q == 0;
    assign pos   = len_q - cnt_q;
    assign par   = (mode0_q[3:2] == MODE_7BIT) ? ^wdata[6:0] : ^wdata;
    assign nb    = (mode0_q[3:2] == MODE_9BIT) ? mode0_q[7] : (!ctrl_q[5] || (ctrl_q[6] ~^ par));
    assign nbits = ((mode0_q[3:2] == MODE_7BIT) ? 8 : 9) + ((ctrl_q[5] || mode0_q[3:2] == MODE_9BIT) ? 1 : 0)
                 + (mode2_q[4] ? 2 : 1);

    // Shadow of the writable settings
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode0_q <= MODE0_RST;
            ctrl_q  <= CTRL_RST;
            mode2_q <= MODE2_RST;
            mask_q  <= 8'h00;
        end else if (wr) begin
            if (addr == {1'b0, MODE0_OFS}) mode0_q <= wdata;
            if (addr == {1'b0, CTRL_OFS}) ctrl_q <= wdata;
            if (addr == {1'b0, MODE2_OFS}) mode2_q <= wdata;
            if (addr == 5'h14) mask_q <= wdata;
        end
    end

    // Expected frame, captured when a character is accepted
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 0;
            len_q <= 0;
            fr_q  <= 13'h1FFF;
        end else if (take) begin
            cnt_q <= nbits * BITC;
            len_q <= nbits * BITC;
            fr_q  <= (mode0_q[3:2] == MODE_7BIT) ? {4'hF, nb, wdata[6:0], 1'b0} : {3'h7, nb, wdata, 1'b0};
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence start_low_s;
        !txd_o [*8];
    endsequence
    sequence mid_bit_s;
        cnt_q != 0 && pos % BITC >= BITC / 4 && pos % BITC < 3 * BITC / 4;
    endsequence

    reset_idle_a: assert property ($fell(rst) |-> txd_o && txd_oe && !receive_irq && !irq)
        else $error("line or interrupts not idle after reset");
    tx_start_a: assert property (take |=> ##1 start_low_s)
        else $error("start bit missing after data write");
    tx_slot_a: assert property (mid_bit_s |-> txd_o == fr_q[pos / BITC])
        else $error("transmitted bit differs from expected frame");
    tx_idle_a: assert property (cnt_q == 0 |-> txd_o)
        else $error("line not high while idle");
    od_level_a: assert property (mode2_q[0] && $past(mode2_q[0]) |-> txd_oe == !txd_o)
        else $error("open drain pin drives high");
    pp_drive_a: assert property (!mode2_q[0] && !$past(mode2_q[0]) |-> txd_oe)
        else $error("push-pull pin not driven");
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside its slot");
    irq_mask_a: assert property (mask_q == 8'h00 && $past(mask_q) == 8'h00 |-> !irq)
        else $error("interrupt with all sources masked");
    stat_clear_a: assert property (rd && addr == 5'h10 |=> !receive_irq)
        else $error("receive interrupt survives status read");
endmodule : uart_frame_props

bind uart_frame_top uart_frame_props #(.BAUD(BAUD)) uart_frame_props_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd),
    .txd_o(txd_o), .txd_oe(txd_oe), .receive_irq(receive_irq), .irq(irq)
);

// file: verification/remote_node.sv
`timescale 1ns/100ps
// ----------------------------------------
// Remote controller on the serial line
// ----------------------------------------
module remote_node (
    input  wire logic clk,
    input  wire logic line,
    output logic      rxd
);
    initial rxd = 1'b1;

    // Sends n bits LSB first, 16 clocks each, and leaves the line at the last bit sent
    task automatic send(input logic [12:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rxd <= f[i];
            repeat (15) @(posedge clk);
        end
    endtask : send

    // Waits for a start bit and samples n bits at their centres
    task automatic grab(input int n, output logic [12:0] f, output logic ok);
        int t;
        f  = 13'h1FFF;
        ok = 1'b0;
        for (t = 0; t < 400 && line; t++) @(posedge clk);
        if (!line) begin
            ok = 1'b1;
            repeat (8) @(posedge clk);
            for (int i = 0; i < n; i++) begin
                f[i] = line;
                if (i < n - 1) repeat (16) @(posedge clk);
            end
        end
    endtask : grab
endmodule : remote_node

// file: verification/tb_uart_frame_top.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fail_count++; $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module tb_uart_frame_top;
    import uart_frame_pkg::*;
    localparam int BAUD = 2_500_000;
    logic        clk, rst, wr, rd, txd_o, txd_oe, receive_irq, irq, ok, nb, st2, od, pe, ev;
    logic [1:0]  md;
    logic [4:0]  addr;
    logic [7:0]  wdata, rdata, v, d;
    logic [12:0] got;
    wire         rxd;
    wire         line = txd_oe ? txd_o : 1'b1;
    int          fail_count, tests_run;
    logic [4:0]  regs [5] = '{5'h00, 5'h04, 5'h08, 5'h14, 5'h1C};
    logic [7:0]  rstv [5] = '{MODE0_RST, CTRL_RST, MODE2_RST, 8'h00, 8'h00};

    uart_frame_top #(.BAUD(BAUD)) uart_frame_top_inst (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd),
        .txd_o(txd_o), .txd_oe(txd_oe), .receive_irq(receive_irq), .irq(irq)
    );
    remote_node remote_node_inst (.clk(clk), .line(line), .rxd(rxd));

    function automatic int flen(input logic [1:0] m, input logic p, input logic s);
        return ((m == MODE_7BIT) ? 8 : 9) + ((p || m == MODE_9BIT) ? 1 : 0) + (s ? 2 : 1);
    endfunction : flen

    function automatic logic [12:0] fbits(input logic [7:0] x, input logic [1:0] m, input logic p, e, n);
        logic b;
        b = (m == MODE_9BIT) ? n : (!p || (e ~^ ((m == MODE_7BIT) ? ^x[6:0] : ^x)));
        return (m == MODE_7BIT) ? {4'hF, b, x[6:0], 1'b0} : {3'h7, b, x, 1'b0};
    endfunction : fbits

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] x);
        @(posedge clk);
        addr  <= a;
        wdata <= x;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [4:0] a, output logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 x = rdata;
    endtask : rd_reg

    task automatic rx_frame(input logic [12:0] f, input int n, input logic exp);
        int t;
        remote_node_inst.send(f, n);
        for (t = 0; t < 40 && !receive_irq; t++) @(posedge clk);
        `CHK("receive_irq", exp, receive_irq)
    endtask : rx_frame

    task automatic end_of_test();
        if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        end_of_test();
    end

    initial begin
        rst        = 1'b1;
        wr         = 1'b0;
        rd         = 1'b0;
        addr       = 5'h00;
        wdata      = 8'h00;
        fail_count = 0;
        tests_run  = 0;
        v          = 8'($urandom(32'h491C1255));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wr_reg(5'h1C, 8'hA5);
        foreach (regs[i]) begin
            rd_reg(regs[i], v);
            `CHK("reset value", rstv[i], v)
        end
        // Transmit every mode and parity choice, with a random stop length
        for (int m = 1; m < 4; m++) begin
            for (int k = 0; k < 4; k++) begin
                d = 8'($urandom);
                {nb, st2, od} = 3'($urandom);
                pe = (m == 3) ? 1'b0 : k[0];
                ev = k[1];
                wr_reg(5'h04, {1'b0, ev, pe, 5'h00});
                wr_reg(5'h08, {3'h0, st2, 3'h0, od});
                wr_reg(5'h00, {nb, 3'h0, 2'(m), 2'h0});
                wr_reg(5'h0C, d);
                fork
                    remote_node_inst.grab(flen(2'(m), pe, st2), got, ok);
                    begin
                        repeat (20) @(posedge clk);
                        wr_reg(5'h0C, ~d);
                        rd_reg(5'h10, v);
                    end
                join
                if (!ok) begin
                    fail_count++;
                    end_of_test();
                end
                `CHK("tx frame", fbits(d, 2'(m), pe, ev, nb), got)
                rd_reg(5'h10, v);
                `CHK("tx busy in last stop", 8'h00, v)
                repeat (8) @(posedge clk);
            end
        end
        `CHK("irq masked", 1'b0, irq)
        wr_reg(5'h14, 8'h02);
        repeat (2) @(posedge clk);
        `CHK("irq unmasked", 1'b1, irq)
        rd_reg(5'h10, v);
        `CHK("status tx", 8'h02, v)
        rd_reg(5'h10, v);
        `CHK("status clear", 8'h00, v)
        `CHK("irq cleared", 1'b0, irq)
        // Receive in 7-bit and 8-bit modes
        wr_reg(5'h14, 8'h01);
        for (int k = 0; k < 4; k++) begin
            d  = 8'($urandom);
            md = (k < 2) ? MODE_7BIT : MODE_8BIT;
            pe = k[0];
            ev = 1'($urandom);
            wr_reg(5'h04, {1'b0, ev, pe, 5'h00});
            wr_reg(5'h00, {2'h0, 1'b1, 1'b0, md, 2'h0});
            rx_frame(fbits(d, md, pe, ev, 1'b0), flen(md, pe, 1'b0), 1'b1);
            rd_reg(5'h04, v);
            `CHK("rx ctrl", {1'b0, ev, pe, 5'h00}, v & 8'h7F)
            rd_reg(5'h0C, v);
            `CHK("rx data", d & ((md == MODE_7BIT) ? 8'h7F : 8'hFF), v & ((md == MODE_7BIT) ? 8'h7F : 8'hFF))
            rd_reg(5'h10, v);
            `CHK("rx status", 8'h01, v)
        end
        // Wake-up filter: data frame ignored, address frame taken
        d = 8'($urandom);
        wr_reg(5'h04, 8'h00);
        wr_reg(5'h00, 8'h3C);
        rx_frame(fbits(~d, MODE_9BIT, 1'b0, 1'b0, 1'b0), flen(MODE_9BIT, 1'b0, 1'b0), 1'b0);
        rx_frame(fbits(d, MODE_9BIT, 1'b0, 1'b0, 1'b1), flen(MODE_9BIT, 1'b0, 1'b0), 1'b1);
        rd_reg(5'h04, v);
        `CHK("ninth bit set", 8'h80, v & 8'h80)
        rd_reg(5'h0C, v);
        `CHK("address code", d, v)
        rd_reg(5'h10, v);
        wr_reg(5'h00, 8'h2C);
        rx_frame(fbits(~d, MODE_9BIT, 1'b0, 1'b0, 1'b0), flen(MODE_9BIT, 1'b0, 1'b0), 1'b1);
        rd_reg(5'h04, v);
        `CHK("ninth bit clear", 8'h00, v & 8'h80)
        rd_reg(5'h0C, v);
        `CHK("selected data", ~d, v)
        end_of_test();
    end
endmodule : tb_uart_frame_top
